// ---- pkg/rws_pkg.sv ----
// Purpose: shared constants and types of the reset and wake status block
// Assumes: 8-bit status layout, 16-bit program counter image
// Notes: reset-cause flags use active-low meaning as seen by software; the two stack flags are active-high
`default_nettype none
package rws_pkg;
	// status flag vector layout
	localparam int RWS_FLAG_W = 8;
	localparam int RWS_FLG_CM = 7;
	localparam int RWS_FLG_RI = 6;
	localparam int RWS_FLG_TO = 5;
	localparam int RWS_FLG_PD = 4;
	localparam int RWS_FLG_POR = 3;
	localparam int RWS_FLG_BOR = 2;
	localparam int RWS_FLG_STACK_FULL_FLAG = 1;
	localparam int RWS_FLG_STACK_UNDERFLOW_FLAG = 0;
	// value after power-on reset
	localparam logic [7:0] RWS_FLAG_POR_VAL = 8'hF0;
	// masks for reset-type updates
	localparam logic [7:0] RWS_BOR_SET = 8'hF0;
	localparam logic [7:0] RWS_BOR_CLR = 8'h04;
	// program counter targets
	localparam int RWS_PC_W = 16;
	localparam logic [15:0] RWS_PC_RESET = 16'h0000;
	localparam logic [15:0] RWS_PC_VEC_HIGH = 16'h0008;
	localparam logic [15:0] RWS_PC_VEC_LOW = 16'h0018;
	localparam logic [15:0] RWS_PC_STEP = 16'h0002;
	// synchroniser reset level for idle-high pins
	localparam logic RWS_PIN_IDLE = 1'b1;

	typedef enum logic [1:0] {
		RWS_ST_ACTIVE = 2'b00,
		RWS_ST_IDLE = 2'b01,
		RWS_ST_SLEEP = 2'b10
	} rws_state_type;

	typedef enum logic [1:0] {
		RWS_PCS_RESET = 2'b00,
		RWS_PCS_NEXT = 2'b01,
		RWS_PCS_VEC_HIGH = 2'b10,
		RWS_PCS_VEC_LOW = 2'b11
	} rws_pcsel_type;
endpackage
`default_nettype wire

// ---- logic/rws_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to sys_clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rws_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pin and filtered level
	input wire logic pin_in,
	output logic level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} rws_sync_state_type;

	rws_sync_state_type st_r;
	rws_sync_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.lvl;
endmodule // rws_sync
`default_nettype wire

// ---- logic/rws_flag_bank.sv ----
// Purpose: bank of status flags with hardware set and clear
// Assumes: set, clear and write come from sys_clk logic
// Notes: hardware set beats clear, both beat a software write
`timescale 1ns/1ps
`default_nettype none
module rws_flag_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// hardware updates
	input wire logic [W-1:0] set_vec,
	input wire logic [W-1:0] clr_vec,
	// software write
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	// flag state
	output logic [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] f;
	} rws_bank_state_type;

	rws_bank_state_type st_r;
	rws_bank_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (wr_en) begin
			st_nxt.f = wr_data;
		end
		st_nxt.f = (st_nxt.f & ~clr_vec) | set_vec;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r.f <= RST_VAL;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flags = st_r.f;
endmodule // rws_flag_bank
`default_nettype wire

// ---- logic/rws_core.sv ----
// Purpose: reset-cause, stack-fault and wake status with pc redirection
// Assumes: event inputs are one-cycle pulses on sys_clk; pins are asynchronous
// Notes: one event is served per cycle, highest priority first
`timescale 1ns/1ps
`default_nettype none
module rws_core
	import rws_pkg::*;
(
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic rst,
	// reset and fault events from the core
	input wire logic brownout_evt,
	input wire logic config_mismatch_evt,
	input wire logic reset_instr_evt,
	input wire logic stack_overflow_evt,
	input wire logic stack_underflow_evt,
	input wire logic watchdog_timeout_evt,
	input wire logic stack_fault_reset_enable,
	// power management
	input wire logic sleep_cmd,
	input wire logic idle_select,
	input wire logic managed_run,
	// interrupt wake
	input wire logic interrupt_wake_evt,
	input wire logic int_is_high_prio,
	input wire logic high_prio_int_global_enable,
	input wire logic low_prio_int_global_enable,
	input wire logic [rws_pkg::RWS_PC_W-1:0] pc_current,
	// external reset pin, active low
	input wire logic external_reset_pin_n,
	// capacitor discharge wake pin and controls
	input wire logic wake_cap_pin_in,
	output logic wake_cap_pin_out,
	output logic wake_cap_pin_oe,
	input wire logic discharge_wake_enable,
	input wire logic discharge_current_sink,
	input wire logic discharge_wake_flag_clr,
	output logic discharge_wake_flag,
	// software access to status flags
	input wire logic flag_wr_en,
	input wire logic [rws_pkg::RWS_FLAG_W-1:0] flag_wr_data,
	// status flags
	output logic config_mismatch_flag,
	output logic reset_instr_flag,
	output logic watchdog_timeout_flag,
	output logic powerdown_flag,
	output logic poweron_flag,
	output logic brownout_flag,
	output logic stack_full_flag,
	output logic stack_underflow_flag,
	// program counter redirection and status
	output logic pc_load,
	output logic [rws_pkg::RWS_PC_W-1:0] pc_value,
	output logic [1:0] pc_source,
	output logic device_reset,
	output logic wake_pulse,
	output logic [1:0] power_state
);
	import rws_pkg::*;

	typedef struct packed {
		rws_state_type state;
		logic xrst_prev;
		logic pc_load;
		logic [RWS_PC_W-1:0] pc_value;
		rws_pcsel_type pc_src;
		logic dev_rst;
		logic wake;
		logic dwf;
		logic sink_oe;
	} rws_core_state_type;

	rws_core_state_type st_r;
	rws_core_state_type st_nxt;

	logic xrst_level;
	logic cap_level;
	logic [RWS_FLAG_W-1:0] flags;
	logic [RWS_FLAG_W-1:0] set_vec;
	logic [RWS_FLAG_W-1:0] clr_vec;
	logic low_power;
	logic xrst_assert;
	logic cap_wake;
	logic [RWS_PC_W-1:0] pc_next_instr;

	rws_sync #(
		.RST_VAL(RWS_PIN_IDLE)
	) u_xrst_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(external_reset_pin_n),
		.level(xrst_level)
	);

	rws_sync #(
		.RST_VAL(RWS_PIN_IDLE)
	) u_cap_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(wake_cap_pin_in),
		.level(cap_level)
	);

	// reset-cause and stack-fault flags
	rws_flag_bank #(
		.W(RWS_FLAG_W),
		.RST_VAL(RWS_FLAG_POR_VAL)
	) u_flags (
		.sys_clk(sys_clk),
		.rst(rst),
		.set_vec(set_vec),
		.clr_vec(clr_vec),
		.wr_en(flag_wr_en),
		.wr_data(flag_wr_data),
		.flags(flags)
	);

	assign low_power = (st_r.state == RWS_ST_IDLE) || (st_r.state == RWS_ST_SLEEP);
	assign xrst_assert = st_r.xrst_prev && !xrst_level;
	assign pc_next_instr = pc_current + RWS_PC_STEP;
	// armed sleep and pin discharged below low threshold
	assign cap_wake = (st_r.state == RWS_ST_SLEEP) && discharge_wake_enable && !cap_level;

	always_comb begin
		st_nxt = st_r;
		set_vec = '0;
		clr_vec = '0;
		st_nxt.xrst_prev = xrst_level;
		st_nxt.pc_load = 1'b0;
		st_nxt.dev_rst = 1'b0;
		st_nxt.wake = 1'b0;
		st_nxt.sink_oe = discharge_wake_enable && discharge_current_sink;
		if (discharge_wake_flag_clr) begin
			st_nxt.dwf = 1'b0;
		end
		if (brownout_evt) begin
			set_vec = RWS_BOR_SET;
			clr_vec = RWS_BOR_CLR;
			st_nxt.dev_rst = 1'b1;
		end else if (config_mismatch_evt) begin
			clr_vec[RWS_FLG_CM] = 1'b1;
			st_nxt.dev_rst = 1'b1;
		end else if (xrst_assert) begin
			st_nxt.dev_rst = 1'b1;
			if (low_power) begin
				set_vec[RWS_FLG_TO] = 1'b1;
				clr_vec[RWS_FLG_PD] = 1'b1;
			end else if (managed_run) begin
				set_vec[RWS_FLG_TO] = 1'b1;
			end
			// full-power pin reset without managed_run leaves flags as they are
		end else if (watchdog_timeout_evt) begin
			clr_vec[RWS_FLG_TO] = 1'b1;
			if (low_power) begin
				clr_vec[RWS_FLG_PD] = 1'b1;
				st_nxt.wake = 1'b1;
			end else begin
				st_nxt.dev_rst = 1'b1;
			end
		end else if (stack_overflow_evt) begin
			set_vec[RWS_FLG_STACK_FULL_FLAG] = 1'b1;
			st_nxt.dev_rst = stack_fault_reset_enable;
		end else if (stack_underflow_evt) begin
			set_vec[RWS_FLG_STACK_UNDERFLOW_FLAG] = 1'b1;
			st_nxt.dev_rst = stack_fault_reset_enable;
		end else if (reset_instr_evt) begin
			clr_vec[RWS_FLG_RI] = 1'b1;
			st_nxt.dev_rst = 1'b1;
		end else if (low_power && (interrupt_wake_evt || cap_wake)) begin
			clr_vec[RWS_FLG_PD] = 1'b1;
			st_nxt.wake = 1'b1;
			if (cap_wake) begin
				st_nxt.dwf = 1'b1;
			end
		end
		// power state sequencing
		case (st_r.state)
			RWS_ST_ACTIVE: begin
				if (sleep_cmd && !st_nxt.dev_rst) begin
					st_nxt.state = idle_select ? RWS_ST_IDLE : RWS_ST_SLEEP;
				end
			end
			RWS_ST_IDLE, RWS_ST_SLEEP: begin
				if (st_nxt.wake || st_nxt.dev_rst) begin
					st_nxt.state = RWS_ST_ACTIVE;
				end
			end
			default: begin
				st_nxt.state = RWS_ST_ACTIVE;
			end
		endcase
		// program counter redirection
		if (st_nxt.dev_rst) begin
			st_nxt.pc_load = 1'b1;
			st_nxt.pc_value = RWS_PC_RESET;
			st_nxt.pc_src = RWS_PCS_RESET;
			st_nxt.state = RWS_ST_ACTIVE;
		end else if (st_nxt.wake) begin
			st_nxt.pc_load = 1'b1;
			st_nxt.pc_value = pc_next_instr;
			st_nxt.pc_src = RWS_PCS_NEXT;
			if (interrupt_wake_evt && !watchdog_timeout_evt
				&& (high_prio_int_global_enable || low_prio_int_global_enable)) begin
				if (int_is_high_prio) begin
					st_nxt.pc_value = RWS_PC_VEC_HIGH;
					st_nxt.pc_src = RWS_PCS_VEC_HIGH;
				end else begin
					st_nxt.pc_value = RWS_PC_VEC_LOW;
					st_nxt.pc_src = RWS_PCS_VEC_LOW;
				end
			end
		end
	end

	// every state field takes a value at power-on reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r.state <= RWS_ST_ACTIVE;
			st_r.xrst_prev <= RWS_PIN_IDLE;
			st_r.pc_load <= 1'b1;
			st_r.pc_value <= RWS_PC_RESET;
			st_r.pc_src <= RWS_PCS_RESET;
			st_r.dev_rst <= 1'b1;
			st_r.wake <= 1'b0;
			st_r.dwf <= 1'b0;
			st_r.sink_oe <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign config_mismatch_flag = flags[RWS_FLG_CM];
	assign reset_instr_flag = flags[RWS_FLG_RI];
	assign watchdog_timeout_flag = flags[RWS_FLG_TO];
	assign powerdown_flag = flags[RWS_FLG_PD];
	assign poweron_flag = flags[RWS_FLG_POR];
	assign brownout_flag = flags[RWS_FLG_BOR];
	assign stack_full_flag = flags[RWS_FLG_STACK_FULL_FLAG];
	assign stack_underflow_flag = flags[RWS_FLG_STACK_UNDERFLOW_FLAG];
	assign discharge_wake_flag = st_r.dwf;
	// sink pulls the pin low only while discharge is enabled
	assign wake_cap_pin_out = 1'b0;
	assign wake_cap_pin_oe = st_r.sink_oe;
	assign pc_load = st_r.pc_load;
	assign pc_value = st_r.pc_value;
	assign pc_source = st_r.pc_src;
	assign device_reset = st_r.dev_rst;
	assign wake_pulse = st_r.wake;
	assign power_state = st_r.state;
endmodule // rws_core
`default_nettype wire

// ---- sim/rws_far.sv ----
// Purpose: far-side model of the wake capacitor and reset pin
// Assumes: one clock, pin levels change after the clock edge
// Notes: charge stands in for the software charging step
`timescale 1ns/1ps
`default_nettype none
module rws_far (
	// clock
	input wire logic sys_clk,
	// software and pin requests
	input wire logic charge,
	input wire logic reset_req,
	// pins
	input wire logic wake_cap_pin_out,
	input wire logic wake_cap_pin_oe,
	output logic wake_cap_pin_in,
	output logic external_reset_pin_n
);
	int v = 0;
	// sink pulls the capacitor down slowly
	always @(posedge sys_clk) begin
		if (charge) v <= 40;
		else if (wake_cap_pin_oe && !wake_cap_pin_out && v > 0) v <= v - 1;
	end
	assign wake_cap_pin_in = v > 10;
	// pull-up when released
	assign external_reset_pin_n = !reset_req;
endmodule // rws_far
`default_nettype wire

// ---- sim/rws_chk.sv ----
// Purpose: assertions on reset-cause and wake behaviour
// Assumes: one clock, synchronous reset
// Notes: bound to rws_core
`timescale 1ns/1ps
`default_nettype none
module rws_chk
	import rws_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// events
	input wire logic brownout_evt,
	input wire logic config_mismatch_evt,
	input wire logic reset_instr_evt,
	input wire logic stack_overflow_evt,
	input wire logic stack_underflow_evt,
	input wire logic watchdog_timeout_evt,
	input wire logic stack_fault_reset_enable,
	input wire logic interrupt_wake_evt,
	input wire logic int_is_high_prio,
	input wire logic high_prio_int_global_enable,
	input wire logic low_prio_int_global_enable,
	input wire logic [rws_pkg::RWS_PC_W-1:0] pc_current,
	// pins
	input wire logic external_reset_pin_n,
	input wire logic wake_cap_pin_in,
	input wire logic discharge_wake_enable,
	// results
	input wire logic config_mismatch_flag,
	input wire logic reset_instr_flag,
	input wire logic watchdog_timeout_flag,
	input wire logic powerdown_flag,
	input wire logic brownout_flag,
	input wire logic stack_full_flag,
	input wire logic stack_underflow_flag,
	input wire logic discharge_wake_flag,
	input wire logic [rws_pkg::RWS_PC_W-1:0] pc_value,
	input wire logic device_reset,
	input wire logic wake_pulse,
	input wire logic [1:0] power_state
);
	logic [5:0] ph;
	always_ff @(posedge sys_clk) ph <= {ph[4:0], external_reset_pin_n};
	wire logic hi = brownout_evt | config_mismatch_evt | ~&ph;
	wire logic lo = watchdog_timeout_evt | stack_overflow_evt | stack_underflow_evt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_POR: assert property (disable iff (1'b0) rst |=> device_reset && pc_value == RWS_PC_RESET
		&& {config_mismatch_flag, reset_instr_flag, stack_full_flag} == 3'h6) else $error("por");
	AST_BOR: assert property (brownout_evt |=> config_mismatch_flag && reset_instr_flag
		&& watchdog_timeout_flag && powerdown_flag && !brownout_flag) else $error("bor");
	AST_CM: assert property (config_mismatch_evt && !brownout_evt
		|=> !config_mismatch_flag && device_reset) else $error("mismatch");
	AST_RI: assert property (reset_instr_evt && !hi && !lo
		|=> !reset_instr_flag && device_reset && pc_value == 16'h0000) else $error("ri");
	AST_WDR: assert property (watchdog_timeout_evt && !hi && power_state == 2'h0
		|=> !watchdog_timeout_flag && device_reset) else $error("wdt run");
	AST_WDW: assert property (watchdog_timeout_evt && !hi && power_state != 2'h0
		|=> !watchdog_timeout_flag && !powerdown_flag && wake_pulse && !device_reset
		&& pc_value == $past(pc_current) + RWS_PC_STEP) else $error("wdt wake");
	AST_STK: assert property ((stack_overflow_evt | stack_underflow_evt) && !hi && !watchdog_timeout_evt
		|=> ($past(stack_overflow_evt) ? stack_full_flag : stack_underflow_flag)
		&& device_reset == $past(stack_fault_reset_enable)) else $error("stack");
	AST_INT: assert property (interrupt_wake_evt && power_state != 2'h0 && !hi && !lo && !reset_instr_evt
		|=> !powerdown_flag && wake_pulse && pc_value == ($past(high_prio_int_global_enable
		| low_prio_int_global_enable) ? ($past(int_is_high_prio) ? RWS_PC_VEC_HIGH : RWS_PC_VEC_LOW)
		: $past(pc_current) + RWS_PC_STEP)) else $error("int wake");
	AST_CAP: assert property ($fell(wake_cap_pin_in) && power_state == 2'h2 && discharge_wake_enable
		|-> ##[1:8] discharge_wake_flag && !powerdown_flag) else $error("cap wake");
	AST_PIN: assert property ($fell(external_reset_pin_n) |-> ##[1:8] device_reset)
		else $error("pin reset");
endmodule // rws_chk
bind rws_core rws_chk u_chk (.*);
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench of the reset and wake status block
// Assumes: 200 MHz clock, drive 1 ns after the edge
// Notes: loads are checked from a note queue
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rws_pkg::*;
	typedef struct packed {logic [7:0] f; logic [15:0] p; logic [1:0] s; logic d;} rws_note_type;
	logic sys_clk = 0, rst = 1, sleep_cmd = 0, idle_select = 0, managed_run = 0, charge = 0;
	logic int_is_high_prio = 0, high_prio_int_global_enable = 0, low_prio_int_global_enable = 0;
	logic stack_fault_reset_enable = 0, discharge_wake_enable = 0, discharge_current_sink = 0;
	logic discharge_wake_flag_clr = 0, flag_wr_en = 0, reset_req = 0;
	logic [6:0] ev_v = 0;
	logic [7:0] flag_wr_data = 0, ef;
	logic [15:0] pc_current = 0;
	wire logic brownout_evt = ev_v[0], config_mismatch_evt = ev_v[1], reset_instr_evt = ev_v[2];
	wire logic stack_overflow_evt = ev_v[3], stack_underflow_evt = ev_v[4];
	wire logic watchdog_timeout_evt = ev_v[5], interrupt_wake_evt = ev_v[6];
	wire logic wake_cap_pin_in, wake_cap_pin_out, wake_cap_pin_oe, external_reset_pin_n;
	wire logic config_mismatch_flag, reset_instr_flag, watchdog_timeout_flag, powerdown_flag;
	wire logic poweron_flag, brownout_flag, stack_full_flag, stack_underflow_flag;
	wire logic discharge_wake_flag, pc_load, device_reset, wake_pulse;
	wire logic [15:0] pc_value;
	wire logic [1:0] pc_source, power_state;
	wire logic [7:0] fl = {config_mismatch_flag, reset_instr_flag, watchdog_timeout_flag,
		powerdown_flag, poweron_flag, brownout_flag, stack_full_flag, stack_underflow_flag};
	rws_note_type q[$];
	int fails = 0, check_count = 0;
	rws_core dut (.*);
	rws_far far (.*);
	always #2.5 sys_clk = ~sys_clk;
	task chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task stop_test;
		if (fails == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wt(input int n);
		for (int i = 0; i < n && q.size() > 0; i++) cyc(1);
		if (q.size() > 0) begin
			chk(1'b0, "timeout");
			stop_test;
		end
	endtask
	task wr;
		flag_wr_data = 8'($urandom);
		flag_wr_en = 1;
		ef = flag_wr_data;
		cyc(1);
		flag_wr_en = 0;
		chk(fl === ef, "write");
	endtask
	task sl(input logic i);
		sleep_cmd = 1;
		idle_select = i;
		cyc(1);
		sleep_cmd = 0;
		chk(power_state === (i ? 2'h1 : 2'h2), "sleep state");
		cyc(1);
		wr;
	endtask
	// p of FFFF marks an event without a load
	task ev(input int k, input logic [7:0] s, c, input logic [15:0] p, input logic [1:0] src,
		input logic d);
		ev_v = 7'h01 << k;
		ef = (ef | s) & ~c;
		if (p !== 16'hFFFF) q.push_back({ef, p, src, d});
		cyc(1);
		ev_v = 0;
		wt(8);
		chk(fl === ef, "flags");
	endtask
	task pin(input logic [7:0] s, c);
		ef = (ef | s) & ~c;
		q.push_back({ef, 16'h0000, 2'h0, 1'b1});
		reset_req = 1;
		wt(10);
		reset_req = 0;
		cyc(8);
	endtask
	always @(posedge sys_clk) begin
		#2;
		if (!rst && pc_load === 1'b1) begin
			if (q.size() == 0) chk(1'b0, "unexpected load");
			else chk({fl, pc_value, pc_source, device_reset} === q.pop_front(), "load");
			chk(wake_pulse === !device_reset && power_state === 2'h0, "load state");
		end
	end
	initial begin
		void'($urandom(32'h83832757));
		pc_current = 16'($urandom) & 16'h7FFE;
		cyc(3);
		q.push_back({RWS_FLAG_POR_VAL, RWS_PC_RESET, 2'h0, 1'b1});
		rst = 0;
		cyc(5);
		ef = RWS_FLAG_POR_VAL;
		chk(fl === ef, "power-on flags");
		wr;
		ev(2, 8'h00, 8'h40, 16'h0000, 2'h0, 1'b1);
		ev(0, 8'hF0, 8'h04, 16'h0000, 2'h0, 1'b1);
		ev(1, 8'h00, 8'h80, 16'h0000, 2'h0, 1'b1);
		stack_fault_reset_enable = 1;
		ev(3, 8'h02, 8'h00, 16'h0000, 2'h0, 1'b1);
		wr;
		ev(4, 8'h01, 8'h00, 16'h0000, 2'h0, 1'b1);
		stack_fault_reset_enable = 0;
		wr;
		ev(4, 8'h01, 8'h00, 16'hFFFF, 2'h0, 1'b0);
		ev(5, 8'h00, 8'h20, 16'h0000, 2'h0, 1'b1);
		sl(0);
		ev(5, 8'h00, 8'h30, pc_current + RWS_PC_STEP, 2'h1, 1'b0);
		high_prio_int_global_enable = 1;
		int_is_high_prio = 1;
		sl(1);
		ev(6, 8'h00, 8'h10, RWS_PC_VEC_HIGH, 2'h2, 1'b0);
		high_prio_int_global_enable = 0;
		low_prio_int_global_enable = 1;
		int_is_high_prio = 0;
		sl(0);
		ev(6, 8'h00, 8'h10, RWS_PC_VEC_LOW, 2'h3, 1'b0);
		low_prio_int_global_enable = 0;
		sl(1);
		ev(6, 8'h00, 8'h10, pc_current + RWS_PC_STEP, 2'h1, 1'b0);
		pin(8'h00, 8'h00);
		managed_run = 1;
		pin(8'h20, 8'h00);
		managed_run = 0;
		sl(1);
		pin(8'h20, 8'h10);
		charge = 1;
		cyc(8);
		charge = 0;
		discharge_wake_enable = 1;
		discharge_current_sink = 1;
		sl(0);
		ef = ef & ~8'h10;
		q.push_back({ef, pc_current + RWS_PC_STEP, 2'h1, 1'b0});
		wt(60);
		chk(discharge_wake_flag === 1'b1, "wake flag");
		chk(wake_cap_pin_oe === 1'b1 && wake_cap_pin_out === 1'b0, "sink on");
		discharge_wake_enable = 0;
		discharge_wake_flag_clr = 1;
		cyc(1);
		discharge_wake_flag_clr = 0;
		cyc(1);
		chk(discharge_wake_flag === 1'b0, "wake flag clear");
		chk(wake_cap_pin_oe === 1'b0, "sink off");
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
